// file: actc_top.sv
// converter timing control: timing register, sequence start, sample/convert sequencer
// assumes an AXI4-Lite master on aclk; analog core consumes phase outputs
// How it works
// [R1] timing register write aborts, never starts sequence
// [R2] bit clear picks 10 bits, set 8
// [R3] 8-bit conversion uses fewer conversion clocks
// [R4] first sampling phase two clocks via buffer
// [R5] second phase 2,4,8,16 clocks by code
// [R6] conversion clock is bus over 2(prs+1)
// [R7] fastest conversion clock is half bus clock
// [R8] divider value resets to five
// [R9] software keeps conversion clock 500kHz to 2MHz
// [R10] resolution bit7, sample 6:5, divider 4:0
// [R11] register readable and writable at any time
// [R12] only sequence start write begins sequence
// [R13] conversion clock is an enable strobe
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
module actc_top
  import actc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             conv_tick,
  output logic             sample_buffered,
  output logic             sample_direct,
  output logic             converting,
  output logic             conv_done
);
  actc_timing_t     timing;
  actc_state_t      state;
  logic [3:0]       aw_addr;
  logic             aw_held;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             w_held;
  logic             do_write;
  logic             wr_timing;
  logic             wr_start;
  logic [4:0]       step;
  logic [4:0]       ph2_len;
  logic [4:0]       conv_len;
  logic             tick;
  logic             restart;
  logic             done_cnt;
  logic             finish;

  // write address and data may arrive in either order; hold each until both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // ready deasserted while a captured beat waits or a response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  assign do_write  = aw_held && w_held && !s_axi_bvalid;
  // writes only count when the low byte lane is enabled
  assign wr_timing = do_write && (aw_addr == ACTC_OFF_TIMING) && w_strb[0];
  assign wr_start  = do_write && (aw_addr == ACTC_OFF_SEQSTART) && w_strb[0];

  // write response; unmapped offsets answer with slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ACTC_RESP_OK;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == ACTC_OFF_TIMING || aw_addr == ACTC_OFF_SEQSTART) begin
        s_axi_bresp <= ACTC_RESP_OK;
      end else if (aw_addr == ACTC_OFF_STATUS) begin
        s_axi_bresp <= ACTC_RESP_OK;
      end else begin
        s_axi_bresp <= ACTC_RESP_ERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // timing register, writable whatever the sequencer is doing [R11]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timing <= actc_timing_t'(ACTC_TIMING_RST);  // [R8]
    end else if (wr_timing) begin
      timing.low_res              <= w_data[ACTC_RES_BIT];  // [R10]
      timing.sample_extend_select <= w_data[ACTC_SMP_LSB +: 2];
      timing.clock_divider_value  <= w_data[ACTC_PRS_LSB +: ACTC_PRS_W];
    end
  end

  // read channel: one outstanding read, answer one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ACTC_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= ACTC_RESP_OK;
      if (s_axi_araddr == ACTC_OFF_TIMING) begin
        s_axi_rdata <= {24'h000000, timing};  // [R11]
      end else if (s_axi_araddr == ACTC_OFF_SEQSTART) begin
        s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_araddr == ACTC_OFF_STATUS) begin
        s_axi_rdata <= {28'h0000000, state};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= ACTC_RESP_ERR;
      end
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // a timing or sequence start write realigns the conversion clock so phases start clean
  assign restart = wr_timing || wr_start;

  actc_prescaler #(
    .PRS_W (ACTC_PRS_W)
  ) u_prescaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (restart),
    .divider (timing.clock_divider_value),
    .tick    (tick)
  );

  // second phase length 2 << code [R5]
  assign ph2_len  = 5'h02 << timing.sample_extend_select;
  // fewer approximation steps when low resolution set [R2] [R3]
  assign conv_len = timing.low_res ? ACTC_BITS_LO : ACTC_BITS_HI;
  assign done_cnt = tick && (step == 5'h01);

  // sequencer: steps count down in conversion clock strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ACTC_IDLE;
      step  <= 5'h00;
    end else if (wr_start) begin  // [R12]
      state <= ACTC_PH1;
      step  <= ACTC_PH1_CYC;  // [R4]
    end else if (wr_timing) begin  // abort only, no restart [R1]
      state <= ACTC_IDLE;
      step  <= 5'h00;
    end else if (tick) begin
      case (state)
        ACTC_PH1: begin
          if (step == 5'h01) begin
            state <= ACTC_PH2;
            step  <= ph2_len;
          end else begin
            step <= step - 5'h01;
          end
        end
        ACTC_PH2: begin
          if (step == 5'h01) begin
            state <= ACTC_CONV;
            step  <= conv_len;
          end else begin
            step <= step - 5'h01;
          end
        end
        ACTC_CONV: begin
          if (step == 5'h01) begin
            state <= ACTC_IDLE;
            step  <= 5'h00;
          end else begin
            step <= step - 5'h01;
          end
        end
        default: begin
          state <= ACTC_IDLE;
          step  <= 5'h00;
        end
      endcase
    end
  end

  // registered phase outputs for the analog core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_tick       <= 1'b0;
      sample_buffered <= 1'b0;
      sample_direct   <= 1'b0;
      converting      <= 1'b0;
      conv_done       <= 1'b0;
      finish          <= 1'b0;
    end else begin
      conv_tick       <= tick;  // [R13]
      sample_buffered <= (state == ACTC_PH1);
      sample_direct   <= (state == ACTC_PH2);
      converting      <= (state == ACTC_CONV);
      // done pulse follows the last converting cycle, not overlapping it
      finish          <= (state == ACTC_CONV) && done_cnt && !restart;
      conv_done       <= finish;
    end
  end

  // tick spacing checks divider: count bus cycles between strobes
  logic [6:0] gap;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap <= 7'h00;
    end else if (restart || tick) begin
      gap <= 7'h01;
    end else begin
      gap <= gap + 7'h01;
    end
  end

  a_tick_period: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    (tick && !restart) |-> (gap == {1'b0, timing.clock_divider_value, 1'b1} + 7'h01))
    else $error("conversion strobe spacing wrong");
  a_tick_min_gap: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    tick |=> !tick)
    else $error("conversion clock above half bus clock");
  a_abort_idle: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    (wr_timing && !wr_start) |=> (state == ACTC_IDLE) ##1 (sample_buffered == 1'b0))
    else $error("timing write did not abort");
  a_start_only: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
    ($past(state) == ACTC_IDLE && state == ACTC_PH1) |-> $past(wr_start))
    else $error("sequence began without start write");
  a_ph1_entry: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    wr_start |=> (state == ACTC_PH1 && step == ACTC_PH1_CYC))
    else $error("first phase not two clocks");
  a_ph2_length: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
    ($past(state) == ACTC_PH1 && state == ACTC_PH2) |-> step == ph2_len)
    else $error("second phase length wrong");
  a_res_steps: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    ($past(state) == ACTC_PH2 && state == ACTC_CONV)
      |-> step == (timing.low_res ? 5'h08 : 5'h0A))
    else $error("conversion length does not match resolution");
  a_low_res_short: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    ($past(state) == ACTC_PH2 && state == ACTC_CONV && timing.low_res)
      |-> step < ACTC_BITS_HI)
    else $error("low resolution not shorter");
  a_reset_value: assert property (@(posedge aclk) // [R8]
    $rose(aresetn) |-> timing.clock_divider_value == 5'h05)
    else $error("divider reset value wrong");
  a_reg_write: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
    wr_timing |=> timing == w_data[7:0] || $past(w_data[7:0]) == timing)
    else $error("timing fields misplaced");
endmodule

// file: actc_pkg.sv
// package for the converter timing control block
// assumes a single 100 MHz bus clock and an AXI4-Lite register port
package actc_pkg;
  // register byte offsets
  localparam logic [3:0] ACTC_OFF_TIMING   = 4'h0;
  localparam logic [3:0] ACTC_OFF_SEQSTART = 4'h4;
  localparam logic [3:0] ACTC_OFF_STATUS   = 4'h8;
  // timing control field positions
  localparam int ACTC_RES_BIT  = 7;
  localparam int ACTC_SMP_LSB  = 5;
  localparam int ACTC_PRS_LSB  = 0;
  localparam int ACTC_PRS_W    = 5;
  // reset values
  localparam logic [7:0] ACTC_TIMING_RST = 8'h05;
  // sample phase one length in conversion clocks
  localparam logic [4:0] ACTC_PH1_CYC  = 5'h02;
  // successive approximation steps per resolution
  localparam logic [4:0] ACTC_BITS_HI  = 5'h0A;
  localparam logic [4:0] ACTC_BITS_LO  = 5'h08;
  // axi response codes
  localparam logic [1:0] ACTC_RESP_OK  = 2'h0;
  localparam logic [1:0] ACTC_RESP_ERR = 2'h2;

  typedef struct packed {
    logic       low_res;
    logic [1:0] sample_extend_select;
    logic [4:0] clock_divider_value;
  } actc_timing_t;

  typedef enum logic [3:0] {
    ACTC_IDLE = 4'b0001,
    ACTC_PH1  = 4'b0010,
    ACTC_PH2  = 4'b0100,
    ACTC_CONV = 4'b1000
  } actc_state_t;
endpackage

// file: actc_prescaler.sv
// conversion clock strobe generator
// assumes divider value is static between restarts; restart realigns it
module actc_prescaler
  import actc_pkg::*;
#(
  parameter int PRS_W = 5
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             restart,
  input  wire logic [PRS_W-1:0] divider,
  output logic                  tick
);
  initial begin
    if (PRS_W < 1 || PRS_W > 8) $error("actc_prescaler: PRS_W out of range");
  end

  // count 2*(divider+1) bus cycles per strobe, one-cycle pulse each time
  logic [PRS_W:0] count;
  logic [PRS_W:0] last;
  assign last = {divider, 1'b1};  // 2*(prs+1)-1 [R6] [R7]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (restart) begin
      // restart counts its own cycle so the first phase is exactly whole strobes
      count <= {{PRS_W{1'b0}}, 1'b1};
      tick  <= 1'b0;
    end else if (count >= last) begin  // [R13]
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule

// file: testbench.sv
// self-checking bench for the converter timing control block
// assumes actc_top with AXI4-Lite slave on aclk; bench is the only bus master
module testbench;
  import actc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        aclk, aresetn;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        conv_tick, sample_buffered, sample_direct, converting, conv_done;
  int          num_errors, n_tests, cyc;
  logic [1:0]  rsp;
  logic [31:0] rd;
  int          n;
  logic [7:0]  seqs [4] = '{8'h00, 8'h20, 8'hC0, 8'hE1};
  // only 1F keeps the conversion clock in 500 kHz..2 MHz at 100 MHz
  logic [4:0]  prs  [3] = '{5'h00, 5'h05, 5'h1F};

  actc_top u_actc_top (.*);

  // bus clock, 10 ns period
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // hang guard: the full run needs well under this many cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // write: address and data offered together, bready held until bvalid
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    bit got;
    got = 0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) begin
        r = s_axi_bresp;
        got = 1;
      end
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    bit got;
    got = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        got = 1;
      end
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  function automatic logic sel(input int k);
    case (k)
      0:       return sample_buffered;
      1:       return sample_direct;
      2:       return converting;
      default: return conv_done;
    endcase
  endfunction

  // waits (bounded) for a level to rise, then counts its high cycles
  task automatic len_of(input int k, output int len);
    int w;
    w = 0;
    len = 0;
    while (!sel(k) && w < 3000) begin
      @(posedge aclk);
      w++;
    end
    while (sel(k)) begin
      len++;
      @(posedge aclk);
    end
  endtask

  // period of the conversion strobe in bus cycles, after a start write
  task automatic tick_period(output int len);
    axi_wr(ACTC_OFF_SEQSTART, 32'h0000_0001, rsp);
    while (!conv_tick) @(posedge aclk);
    @(posedge aclk);
    len = 1;
    while (!conv_tick) begin
      len++;
      @(posedge aclk);
    end
  endtask

  // one full sequence with a given timing value, phase lengths in bus cycles
  task automatic run_seq(input logic [7:0] t);
    int per;
    per = 2 * (int'(t[4:0]) + 1);
    axi_wr(ACTC_OFF_TIMING, {24'h0, t}, rsp);
    axi_wr(ACTC_OFF_SEQSTART, 32'h0000_0001, rsp);
    len_of(0, n);
    check(n, 2 * per);
    len_of(1, n);
    check(n, (2 << t[6:5]) * per);
    len_of(2, n);
    check(n, (t[7] ? 8 : 10) * per);
    len_of(3, n);
    check(n, 1);
  endtask

  task automatic test_reset_and_map();
    axi_rd(ACTC_OFF_TIMING, rd, rsp);
    check(rd, 32'h0000_0005);
    axi_rd(ACTC_OFF_STATUS, rd, rsp);
    check(rd, 32'h0000_0001);
    tick_period(n);
    check(n, 12);
    axi_wr(ACTC_OFF_TIMING, 32'h0000_00E3, rsp);
    axi_rd(ACTC_OFF_TIMING, rd, rsp);
    check(rd, 32'h0000_00E3);
    axi_wr(4'hC, 32'h0000_0001, rsp);
    check(rsp, ACTC_RESP_ERR);
    axi_rd(4'hC, rd, rsp);
    check(rsp, ACTC_RESP_ERR);
    check(rd, 32'h0000_0000);
  endtask

  task automatic test_divider();
    foreach (prs[i]) begin
      axi_wr(ACTC_OFF_TIMING, {27'h0, prs[i]}, rsp);
      tick_period(n);
      check(n, 2 * (int'(prs[i]) + 1));
    end
  endtask

  // timing write mid-sequence aborts; start write mid-sequence restarts
  task automatic test_abort_restart();
    axi_wr(ACTC_OFF_TIMING, 32'h0000_0060, rsp);
    axi_wr(ACTC_OFF_SEQSTART, 32'h0000_0001, rsp);
    while (!sample_direct) @(posedge aclk);
    axi_wr(ACTC_OFF_TIMING, 32'h0000_0060, rsp);
    axi_rd(ACTC_OFF_TIMING, rd, rsp);
    check(rd, 32'h0000_0060);
    n = 0;
    repeat (100) begin
      @(posedge aclk);
      if (sample_buffered || sample_direct || converting || conv_done) n++;
    end
    check(n, 0);
    axi_rd(ACTC_OFF_STATUS, rd, rsp);
    check(rd, 32'h0000_0001);
    axi_wr(ACTC_OFF_TIMING, 32'h0000_0000, rsp);
    axi_wr(ACTC_OFF_SEQSTART, 32'h0000_0001, rsp);
    while (!converting) @(posedge aclk);
    axi_wr(ACTC_OFF_SEQSTART, 32'h0000_0001, rsp);
    len_of(0, n);
    check(n, 4);
  endtask

  initial begin
    {s_axi_awaddr, s_axi_wstrb, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    num_errors = 0;
    n_tests = 0;
    cyc = 0;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    test_reset_and_map();
    test_divider();
    foreach (seqs[i]) run_seq(seqs[i]);
    test_abort_restart();
    wrap_up();
  end
endmodule
